// ---- logic/ocd_osc_div.sv ----
// On-chip oscillator with binary divider and configuration timing.
// Assumes clk stands for the oscillator; configuration logic drives cfg_done.
//
// What this block does
// - Oscillator times power-on delay, memory clearing, and clocks master configuration.
// - Nominal 8 MHz; logic tolerates anything from 4 to 10 MHz.
// - After configuration the undivided clock may be offered to user logic.
// - Divider taps at bits four, nine, fourteen, nineteen, each resynchronised.
// - Any two of the four resynchronised taps go out with the primary.
// - Oscillator stops after configuration if the access element is unused.
`timescale 1ns/10ps
module ocd_osc_div
  import ocd_pkg::*;
#(
  parameter int POR_LEN = POR_CYCLES,
  parameter int CLEAR_LEN = CLEAR_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Configuration side
  input wire logic master_mode,
  input wire logic cfg_done,
  input wire logic access_used,
  input wire logic primary_en_cfg,
  input wire logic [1:0] sel_a_cfg,
  input wire logic [1:0] sel_b_cfg,
  output logic por_done,
  output logic clear_done,
  output logic configuration_clock,
  output logic osc_running,
  // User side
  output logic user_clk_en,
  output logic user_tap_a,
  output logic user_tap_b
);
  ////////////////////////////////////////////////////////////////////////
  // Divider and tap resync
  ocd_tap_if taps ();
  logic [DIV_BITS-1:0] div;
  logic [DIV_BITS-1:0] next_div;
  logic run;

  function automatic logic pick(input logic [3:0] v, input logic [1:0] s);
    pick = v[s];
  endfunction

  always_comb begin
    next_div = run ? div + 1'b1 : div;
  end

  always_ff @(posedge clk) begin
    if (!rstn) div <= '0;
    else div <= next_div;
  end

  // Synchronous binary counter stands in for the ripple chain
  assign taps.raw = {div[TAP3_STAGE-1], div[TAP2_STAGE-1], div[TAP1_STAGE-1],
                     div[TAP0_STAGE-1]};

  ocd_resync u_resync (
    .clk(clk),
    .rstn(rstn),
    .taps(taps)
  );

  ////////////////////////////////////////////////////////////////////////
  // Configuration sequencing
  ocd_state_t state;
  ocd_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [1:0] sel_a;
  logic [1:0] sel_b;
  logic [1:0] next_sel_a;
  logic [1:0] next_sel_b;
  logic prim_en;
  logic next_prim_en;
  logic cfg_div;
  logic next_cfg_div;

  // Counts in oscillator cycles, so the real time scales with the 4-10 MHz spread
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sel_a = sel_a;
    next_sel_b = sel_b;
    next_prim_en = prim_en;
    next_cfg_div = 1'b0;
    case (state)
      OCD_POR: begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(POR_LEN - 1)) begin
          next_state = OCD_CLEAR;
          next_cnt = '0;
        end
      end
      OCD_CLEAR: begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(CLEAR_LEN - 1)) begin
          next_state = OCD_LOAD;
          next_cnt = '0;
        end
      end
      OCD_LOAD: begin
        next_cfg_div = master_mode ? ~cfg_div : 1'b0;
        next_sel_a = sel_a_cfg;
        next_sel_b = sel_b_cfg;
        next_prim_en = primary_en_cfg;
        if (cfg_done) next_state = access_used ? OCD_USER : OCD_OFF;
      end
      OCD_USER: begin
        // Selection frozen here
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= OCD_POR;
      cnt <= '0;
      sel_a <= SEL_A_RST;
      sel_b <= SEL_B_RST;
      prim_en <= 1'b0;
      cfg_div <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sel_a <= next_sel_a;
      sel_b <= next_sel_b;
      prim_en <= next_prim_en;
      cfg_div <= next_cfg_div;
    end
  end

  assign run = (state != OCD_OFF);

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  logic next_por_done;
  logic next_clear_done;
  logic next_user_clk_en;
  logic next_tap_a;
  logic next_tap_b;
  logic next_osc_running;

  always_comb begin
    next_por_done = (next_state != OCD_POR);
    next_clear_done = (next_state == OCD_LOAD) || (next_state == OCD_USER) ||
                      (next_state == OCD_OFF);
    next_user_clk_en = (next_state == OCD_USER) && next_prim_en;
    next_tap_a = (next_state == OCD_USER) && pick(taps.sync, next_sel_a);
    next_tap_b = (next_state == OCD_USER) && pick(taps.sync, next_sel_b);
    next_osc_running = (next_state != OCD_OFF);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      por_done <= 1'b0;
      clear_done <= 1'b0;
      configuration_clock <= 1'b0;
      osc_running <= 1'b1;
      user_clk_en <= 1'b0;
      user_tap_a <= 1'b0;
      user_tap_b <= 1'b0;
    end else begin
      por_done <= next_por_done;
      clear_done <= next_clear_done;
      configuration_clock <= next_cfg_div;
      osc_running <= next_osc_running;
      user_clk_en <= next_user_clk_en;
      user_tap_a <= next_tap_a;
      user_tap_b <= next_tap_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_OFF_STOPS: assert property (@(posedge clk) disable iff (!rstn)
    (state == OCD_OFF) |=> $stable(div))
    else $error("divider moved while oscillator off");
  AST_NO_ACCESS_OFF: assert property (@(posedge clk) disable iff (!rstn)
    (state == OCD_LOAD && cfg_done && !access_used) |=> !osc_running)
    else $error("oscillator not stopped");
  AST_POR_TIME: assert property (@(posedge clk) disable iff (!rstn)
    (state == OCD_POR && cnt == CNT_W'(POR_LEN - 1)) |=> state == OCD_CLEAR)
    else $error("power-on delay wrong length");
  AST_CLEAR_TIME: assert property (@(posedge clk) disable iff (!rstn)
    (state == OCD_CLEAR && cnt == CNT_W'(CLEAR_LEN - 1)) |=> state == OCD_LOAD)
    else $error("clearing wrong length");
  AST_CONFIGURATION_CLOCK_TOGGLE: assert property (@(posedge clk) disable iff (!rstn)
    (state == OCD_LOAD && $past(state) == OCD_LOAD && master_mode && $past(master_mode))
    |=> configuration_clock != $past(configuration_clock))
    else $error("configuration clock not toggling");
  AST_CONFIGURATION_CLOCK_IDLE: assert property (@(posedge clk) disable iff (!rstn)
    (state != OCD_LOAD || !master_mode) |=> !configuration_clock)
    else $error("configuration clock active outside master loading");
  AST_SEL_FROZEN: assert property (@(posedge clk) disable iff (!rstn)
    (state == OCD_USER) |=> $stable(sel_a) && $stable(sel_b))
    else $error("tap selection changed in user mode");
  AST_STATE_FINAL: assert property (@(posedge clk) disable iff (!rstn)
    (state == OCD_USER || state == OCD_OFF) |=> state == $past(state))
    else $error("left a final state");
  AST_USER_ONLY: assert property (@(posedge clk) disable iff (!rstn)
    (user_clk_en || user_tap_a || user_tap_b) |-> $past(state) == OCD_USER ||
    state == OCD_USER)
    else $error("user outputs active before configuration");
  AST_CLK_EN: assert property (@(posedge clk) disable iff (!rstn)
    (state == OCD_USER) |=> user_clk_en == $past(prim_en))
    else $error("primary clock enable mismatch");
  AST_TAP_A: assert property (@(posedge clk) disable iff (!rstn)
    (state == OCD_USER && $past(state) == OCD_USER) |=>
    user_tap_a == pick($past(taps.sync), sel_a))
    else $error("tap a mismatch");
  AST_TAP_B: assert property (@(posedge clk) disable iff (!rstn)
    (state == OCD_USER && $past(state) == OCD_USER) |=>
    user_tap_b == pick($past(taps.sync), sel_b))
    else $error("tap b mismatch");
  AST_RESYNC: assert property (@(posedge clk) disable iff (!rstn)
    (run && $past(run, 2)) |-> taps.sync == $past(taps.raw, 2))
    else $error("tap resync latency wrong");
endmodule // ocd_osc_div

// ---- common/ocd_pkg.sv ----
// Package for the on-chip oscillator and divider block.
// Assumes a single 10 MHz system clock that models the oscillator itself.
package ocd_pkg;
  // Nominal oscillator rate and the rate of the modelling clock
  localparam int OSC_NOM_HZ = 8000000;
  localparam int OSC_MIN_HZ = 4000000;
  localparam int OSC_MAX_HZ = 10000000;
  localparam int CLK_HZ = 10000000;
  // Divider stages, counted from one
  localparam int DIV_BITS = 19;
  localparam int TAP0_STAGE = 4;
  localparam int TAP1_STAGE = 9;
  localparam int TAP2_STAGE = 14;
  localparam int TAP3_STAGE = 19;
  localparam int NUM_TAPS = 4;
  localparam int SEL_W = 2;
  // Tap selection held until configuration loads one
  localparam logic [SEL_W-1:0] SEL_A_RST = 2'h0;
  localparam logic [SEL_W-1:0] SEL_B_RST = 2'h1;
  // Configuration timing, in oscillator cycles
  localparam int POR_CYCLES = 64;
  localparam int CLEAR_CYCLES = 32;
  localparam int CNT_W = 16;
  // Configuration clock is the oscillator divided by this
  localparam int CFG_DIV = 2;
  typedef enum logic [2:0] {
    OCD_POR, OCD_CLEAR, OCD_LOAD, OCD_USER, OCD_OFF
  } ocd_state_t;
endpackage

// ---- common/ocd_tap_if.sv ----
// Carries raw divider taps and their resynchronised copies.
// Assumes both ends share the one clock.
`timescale 1ns/10ps
interface ocd_tap_if;
  logic [3:0] raw;
  logic [3:0] sync;
  modport src (output raw, input sync);
  modport dst (input raw, output sync);
endinterface

// ---- logic/ocd_resync.sv ----
// Two-stage resynchroniser for the divider taps.
// Assumes taps come from the same clock as the flops here.
`timescale 1ns/10ps
module ocd_resync
  import ocd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Taps
  ocd_tap_if.dst taps
);
  logic [NUM_TAPS-1:0] stage1;
  logic [NUM_TAPS-1:0] stage2;
  logic [NUM_TAPS-1:0] next_stage1;
  logic [NUM_TAPS-1:0] next_stage2;

  always_comb begin
    next_stage1 = taps.raw;
    next_stage2 = stage1;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign taps.sync = stage2;
endmodule // ocd_resync

// ---- verif/ocd_osc_div_test.sv ----
// Bench for the oscillator divider: configuration walk, taps, shutdown.
// Assumes clk stands for the oscillator; the bench plays configuration logic.
`timescale 1ns/10ps
module ocd_osc_div_test;
  import ocd_pkg::*;
  // Short counts keep each walk brief
  localparam int PL = 4;
  localparam int CL = 4;
  localparam int WIN = 1024;
  // Two edges of the fourteenth stage; the last stage would need far too long
  localparam int WIN_LONG = 16384;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic master_mode = 1'b0;
  logic cfg_done = 1'b0;
  logic access_used = 1'b1;
  logic primary_en_cfg = 1'b0;
  logic [1:0] sel_a_cfg = 2'h0;
  logic [1:0] sel_b_cfg = 2'h1;
  logic por_done, clear_done, configuration_clock, osc_running;
  logic user_clk_en, user_tap_a, user_tap_b;
  int n_errors = 0;
  int check_count = 0;
  ocd_osc_div #(.POR_LEN(PL), .CLEAR_LEN(CL)) dut_u (.clk(clk), .rstn(rstn),
    .master_mode(master_mode), .cfg_done(cfg_done), .access_used(access_used),
    .primary_en_cfg(primary_en_cfg), .sel_a_cfg(sel_a_cfg), .sel_b_cfg(sel_b_cfg),
    .por_done(por_done), .clear_done(clear_done),
    .configuration_clock(configuration_clock), .osc_running(osc_running),
    .user_clk_en(user_clk_en), .user_tap_a(user_tap_a), .user_tap_b(user_tap_b));
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Windows span whole tap periods except at the last stage, which has no edge inside them, so the edge count is exact
  function automatic int exp_tr(input int w, input logic [1:0] s);
    int stg;
    stg = (s == 2'h0) ? TAP0_STAGE : (s == 2'h1) ? TAP1_STAGE :
          (s == 2'h2) ? TAP2_STAGE : TAP3_STAGE;
    return w >> (stg - 1);
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic run_cfg(input logic m, acc, prim, input logic [1:0] sa, sb, input int win);
    int n;
    int ta;
    int tb;
    logic pa;
    logic pb;
    @(posedge clk);
    master_mode <= m;
    access_used <= acc;
    primary_en_cfg <= prim;
    sel_a_cfg <= sa;
    sel_b_cfg <= sb;
    rstn <= 1'b0;
    cfg_done <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk("osc_running", 1, osc_running);
    chk("reset_cfg_clk", 0, configuration_clock);
    chk("reset_outs", 0, {por_done, clear_done, user_clk_en, user_tap_a, user_tap_b});
    @(posedge clk);
    rstn <= 1'b1;
    n = 0;
    while (por_done !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    chk("por_delay", 1, n >= PL && n <= PL + 2);
    n = 0;
    while (clear_done !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    chk("clear_delay", 1, n >= CL && n <= CL + 2);
    tick();
    tick();
    pa = configuration_clock;
    ta = 0;
    repeat (8) begin
      tick();
      ta += (configuration_clock !== pa);
      pa = configuration_clock;
    end
    chk("cfg_clk_toggles", m ? 8 : 0, ta);
    @(posedge clk);
    cfg_done <= 1'b1;
    // Move the selection only once the choice is committed
    repeat (2) @(posedge clk);
    sel_a_cfg <= ~sa;
    sel_b_cfg <= ~sb;
    tick();
    chk("osc_running", acc, osc_running);
    chk("user_clk_en", acc & prim, user_clk_en);
    pa = user_tap_a;
    pb = user_tap_b;
    ta = 0;
    tb = 0;
    repeat (win) begin
      tick();
      ta += (user_tap_a !== pa);
      tb += (user_tap_b !== pb);
      pa = user_tap_a;
      pb = user_tap_b;
    end
    chk("tap_a_toggles", acc ? exp_tr(win, sa) : 0, ta);
    chk("tap_b_toggles", acc ? exp_tr(win, sb) : 0, tb);
    chk("user_clk_en", acc & prim, user_clk_en);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic scn_master_fast_taps();
    run_cfg(1'b1, 1'b1, 1'b1, 2'h0, 2'h1, WIN);
  endtask
  task automatic scn_plain_slow_taps();
    run_cfg(1'b0, 1'b1, 1'b0, 2'h2, 2'h3, WIN_LONG);
  endtask
  task automatic scn_master_swapped();
    run_cfg(1'b1, 1'b1, 1'b1, 2'h1, 2'h0, WIN);
  endtask
  task automatic scn_plain_swapped_slow();
    run_cfg(1'b0, 1'b1, 1'b1, 2'h3, 2'h2, WIN_LONG);
  endtask
  task automatic scn_unused_stops();
    run_cfg(1'b1, 1'b0, 1'b1, 2'h0, 2'h1, WIN);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    scn_master_fast_taps();
    scn_plain_slow_taps();
    scn_master_swapped();
    scn_plain_swapped_slow();
    scn_unused_stops();
    end_of_test();
  end
  // Five walks take about 36000 cycles, two of them long
  initial begin
    #5000000;
    n_errors++;
    end_of_test();
  end
endmodule // ocd_osc_div_test
